/* File: bcf_link_framer.sv */
`timescale 1ns/10ps
module bcf_link_framer
  import bcf_pkg::*;
(
  input  wire logic                   clock_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   sysref_i,
  input  wire logic                   fec_mode_i,
  input  wire logic [BCF_DATA_W-1:0]  block_data_i,
  input  wire logic                   block_valid_i,
  output logic      [BCF_BLOCK_W-1:0] block_o,
  output logic                        block_valid_o,
  output logic      [BCF_IDX_W-1:0]   block_index_o,
  output logic                        local_ext_multiblock_clock_o
);
  logic                   sysref_meta;
  logic                   sysref_sync;
  logic                   sysref_prev;
  logic                   sysref_rise;
  logic [BCF_IDX_W-1:0]   blk_count;
  logic [BCF_IDX_W-1:0]   next_blk_count;
  logic [BCF_IDX_W-1:0]   cur_idx;
  logic [BCF_CRC_W-1:0]   crc_held;
  logic [BCF_CRC_W-1:0]   next_crc_held;
  logic [BCF_FEC_W-1:0]   fec_held;
  logic [BCF_FEC_W-1:0]   next_fec_held;
  logic [BCF_CRC_W-1:0]   crc_next;
  logic [BCF_FEC_W-1:0]   fec_next;
  logic [BCF_DATA_W-1:0]  line_bits;
  logic [31:0]            stream_word;
  logic                   stream_bit;
  logic                   mb_first;
  logic                   mb_last;
  logic [BCF_BLOCK_W-1:0] next_block;
  logic                   next_block_valid;
  logic [BCF_IDX_W-1:0]   next_block_index;
  logic                   next_local_ext_multiblock_clock;
  logic                   next_sysref_meta;
  logic                   next_sysref_sync;
  logic                   next_sysref_prev;
  logic [31:0]            crc_word;
  logic [31:0]            fec_word;
  logic                   mode_hold;
  logic                   next_mode_hold;
  logic                   mb_mode;
  logic [1:0]             block_header;

  // Pin input, two flops before use; the third only feeds the edge detector
  always_comb begin
    next_sysref_meta = sysref_i;
    next_sysref_sync = sysref_meta;
    next_sysref_prev = sysref_sync;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sysref_meta <= 1'b0;
      sysref_sync <= 1'b0;
      sysref_prev <= 1'b0;
    end else begin
      sysref_meta <= next_sysref_meta;
      sysref_sync <= next_sysref_sync;
      sysref_prev <= next_sysref_prev;
    end
  end

  assign sysref_rise = sysref_sync & ~sysref_prev;

  // A SYSREF rising edge makes the block of this cycle block 0
  assign cur_idx  = sysref_rise ? BCF_FIRST_IDX : blk_count;
  assign mb_first = (cur_idx == BCF_FIRST_IDX);
  assign mb_last  = (cur_idx == BCF_LAST_IDX);

  // Line order: octet 0 first, each octet MSB first
  for (genvar o = 0; o < BCF_DATA_W / BCF_OCTET_W; o++) begin : g_octet
    for (genvar b = 0; b < BCF_OCTET_W; b++) begin : g_bit
      assign line_bits[o * BCF_OCTET_W + b] =
        block_data_i[o * BCF_OCTET_W + BCF_OCTET_W - 1 - b];
    end
  end

  bcf_parity_gen #(
    .WIDTH (BCF_CRC_W),
    .TAPS  (BCF_CRC_TAPS)
  ) u_crc (
    .clock_i      (clock_i),
    .rst_n_i      (rst_n_i),
    .valid_i      (block_valid_i),
    .first_i      (mb_first),
    .line_bits_i  (line_bits),
    .next_state_o (crc_next)
  );

  bcf_parity_gen #(
    .WIDTH (BCF_FEC_W),
    .TAPS  (BCF_FEC_TAPS)
  ) u_fec (
    .clock_i      (clock_i),
    .rst_n_i      (rst_n_i),
    .valid_i      (block_valid_i),
    .first_i      (mb_first),
    .line_bits_i  (line_bits),
    .next_state_o (fec_next)
  );

  // CRC layout by position; parity MSB first, command word zero
  always_comb begin
    crc_word     = BCF_ALL_ZERO;
    crc_word[0]  = crc_held[11];
    crc_word[1]  = crc_held[10];
    crc_word[2]  = crc_held[9];
    crc_word[3]  = 1'b1;

    crc_word[4]  = crc_held[8];
    crc_word[5]  = crc_held[7];
    crc_word[6]  = crc_held[6];
    crc_word[7]  = 1'b1;

    crc_word[8]  = crc_held[5];
    crc_word[9]  = crc_held[4];
    crc_word[10] = crc_held[3];
    crc_word[11] = 1'b1;

    crc_word[12] = crc_held[2];
    crc_word[13] = crc_held[1];
    crc_word[14] = crc_held[0];
    crc_word[15] = 1'b1;

    crc_word[16] = 1'b0;
    crc_word[17] = 1'b0;
    crc_word[18] = 1'b0;
    crc_word[19] = 1'b1;

    crc_word[20] = 1'b0;
    crc_word[21] = 1'b1;
    crc_word[BCF_POS_EXT_MULTIBLOCK_END_BIT] = (BCF_E_COUNT == 1);
    crc_word[23] = 1'b1;

    crc_word[24] = 1'b0;
    crc_word[25] = 1'b0;
    crc_word[26] = 1'b0;
    crc_word[27] = 1'b0;

    crc_word[28] = 1'b0;
    crc_word[29] = 1'b0;
    crc_word[30] = 1'b0;
    crc_word[BCF_POS_PILOT1] = 1'b1;
  end

  // FEC layout by position; parity MSB first
  always_comb begin
    fec_word     = BCF_ALL_ZERO;
    fec_word[0]  = fec_held[25];
    fec_word[1]  = fec_held[24];
    fec_word[2]  = fec_held[23];
    fec_word[3]  = fec_held[22];

    fec_word[4]  = fec_held[21];
    fec_word[5]  = fec_held[20];
    fec_word[6]  = fec_held[19];
    fec_word[7]  = fec_held[18];

    fec_word[8]  = fec_held[17];
    fec_word[9]  = fec_held[16];
    fec_word[10] = fec_held[15];
    fec_word[11] = fec_held[14];

    fec_word[12] = fec_held[13];
    fec_word[13] = fec_held[12];
    fec_word[14] = fec_held[11];
    fec_word[15] = fec_held[10];

    fec_word[16] = fec_held[9];
    fec_word[17] = fec_held[8];
    fec_word[18] = fec_held[7];
    fec_word[19] = fec_held[6];

    fec_word[20] = fec_held[5];
    fec_word[21] = fec_held[4];
    fec_word[BCF_POS_EXT_MULTIBLOCK_END_BIT] = (BCF_E_COUNT == 1);
    fec_word[23] = fec_held[3];

    fec_word[24] = fec_held[2];
    fec_word[25] = fec_held[1];
    fec_word[26] = fec_held[0];
    fec_word[27] = 1'b0;

    fec_word[28] = 1'b0;
    fec_word[29] = 1'b0;
    fec_word[30] = 1'b0;
    fec_word[BCF_POS_PILOT1] = 1'b1;
  end

  // Mode taken at block 0, so one stream word never mixes both layouts
  assign mb_mode     = mb_first ? fec_mode_i : mode_hold;
  assign stream_word = mb_mode ? fec_word : crc_word;
  assign stream_bit  = stream_word[cur_idx];

  always_comb begin
    next_blk_count = cur_idx;
    if (block_valid_i) begin
      next_blk_count = cur_idx + 5'h01;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blk_count <= BCF_FIRST_IDX;
    end else begin
      blk_count <= next_blk_count;
    end
  end

  always_comb begin
    next_mode_hold = mode_hold;
    if (block_valid_i && mb_first) begin
      next_mode_hold = fec_mode_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_hold <= 1'b0;
    end else begin
      mode_hold <= next_mode_hold;
    end
  end

  // Parity of this multiblock goes out in the next one
  always_comb begin
    next_crc_held = crc_held;
    next_fec_held = fec_held;
    if (block_valid_i && mb_last) begin
      next_crc_held = crc_next;
      next_fec_held = fec_next;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_held <= BCF_CRC_RESET;
      fec_held <= BCF_FEC_RESET;
    end else begin
      crc_held <= next_crc_held;
      fec_held <= next_fec_held;
    end
  end

  // Header bit 1 is the stream bit, bit 0 its complement
  assign block_header[1] = stream_bit;
  assign block_header[0] = ~stream_bit;

  always_comb begin
    next_block       = block_o;
    next_block_valid = block_valid_i;
    next_block_index = block_index_o;
    next_local_ext_multiblock_clock        = 1'b0;
    if (block_valid_i) begin
      next_block       = {line_bits, block_header};
      next_block_index = cur_idx;
      next_local_ext_multiblock_clock        = mb_last;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      block_o       <= '0;
      block_valid_o <= 1'b0;
      block_index_o <= BCF_FIRST_IDX;
      local_ext_multiblock_clock_o        <= 1'b0;
    end else begin
      block_o       <= next_block;
      block_valid_o <= next_block_valid;
      block_index_o <= next_block_index;
      local_ext_multiblock_clock_o        <= next_local_ext_multiblock_clock;
    end
  end
endmodule

/* File: bcf_link_framer_sva.sv */
`timescale 1ns/10ps
module bcf_link_framer_sva
  import bcf_pkg::*;
(
  input wire logic                   clock_i,
  input wire logic                   rst_n_i,
  input wire logic                   sysref_i,
  input wire logic                   fec_mode_i,
  input wire logic [BCF_DATA_W-1:0]  block_data_i,
  input wire logic                   block_valid_i,
  input wire logic [BCF_BLOCK_W-1:0] block_o,
  input wire logic                   block_valid_o,
  input wire logic [BCF_IDX_W-1:0]   block_index_o,
  input wire logic                   local_ext_multiblock_clock_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_vld; 1'b1 |=> block_valid_o == $past(block_valid_i); endproperty
  a_vld: assert property (p_vld) else $error("valid latency");
  property p_dat; block_valid_i |=> block_o[2] == $past(block_data_i[7])
    && block_o[9] == $past(block_data_i[0]) && block_o[65] == $past(block_data_i[56]); endproperty
  a_dat: assert property (p_dat) else $error("octet placement");
  property p_hdr; block_valid_o |-> block_o[0] != block_o[1]; endproperty
  a_hdr: assert property (p_hdr) else $error("header not complementary");
  // Sysref quiet for four cycles so no phase reset can land between the blocks
  property p_idx; $stable(sysref_i)[*4] ##0 block_valid_o ##1 block_valid_o
    |-> block_index_o == $past(block_index_o) + 5'h01; endproperty
  a_idx: assert property (p_idx) else $error("index step");
  property p_tick; local_ext_multiblock_clock_o == (block_valid_o && block_index_o == 5'h1f); endproperty
  a_tick: assert property (p_tick) else $error("tick misplaced");
  property p_multiblock_end_pilot; block_valid_o && block_index_o inside {[5'h1b:5'h1e]}
    |-> block_o[1:0] == 2'b01; endproperty
  a_multiblock_end_pilot: assert property (p_multiblock_end_pilot) else $error("pilot zeros");
  property p_end; block_valid_o && block_index_o inside {5'h16, 5'h1f}
    |-> block_o[1:0] == 2'b10; endproperty
  a_end: assert property (p_end) else $error("end bits");
  property p_cmd; block_valid_o && !$past(fec_mode_i)
    && block_index_o inside {[5'h10:5'h12], 5'h14, [5'h18:5'h1a]} |-> block_o[1:0] == 2'b01;
  endproperty
  a_cmd: assert property (p_cmd) else $error("command bits");
endmodule
bind bcf_link_framer bcf_link_framer_sva u_sva (.clock_i, .rst_n_i, .sysref_i, .fec_mode_i,
  .block_data_i, .block_valid_i, .block_o, .block_valid_o, .block_index_o, .local_ext_multiblock_clock_o);

/* File: bcf_parity_gen.sv */
`timescale 1ns/10ps
module bcf_parity_gen
  import bcf_pkg::*;
#(
  parameter int unsigned     WIDTH = BCF_CRC_W,
  parameter logic [WIDTH-1:0] TAPS  = BCF_CRC_TAPS[WIDTH-1:0]
) (
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  valid_i,
  input  wire logic                  first_i,
  input  wire logic [BCF_DATA_W-1:0] line_bits_i,
  output logic      [WIDTH-1:0]      next_state_o
);
  logic [WIDTH-1:0] state;
  logic [WIDTH-1:0] next_state;
  logic [WIDTH-1:0] run;
  logic             fb;

  always_comb begin
    run = first_i ? '0 : state;
    fb  = 1'b0;
    for (int i = 0; i < BCF_DATA_W; i++) begin
      // Line bit 0 enters first
      fb  = line_bits_i[i] ^ run[WIDTH-1];
      run = {run[WIDTH-2:0], 1'b0} ^ (fb ? TAPS : '0);
    end
    next_state_o = run;
    next_state   = valid_i ? run : state;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule

/* File: bcf_pkg.sv */
package bcf_pkg;
  localparam int unsigned BCF_DATA_W     = 64;
  localparam int unsigned BCF_BLOCK_W    = 66;
  localparam int unsigned BCF_SH_W       = 2;
  localparam int unsigned BCF_OCTET_W    = 8;
  localparam int unsigned BCF_MB_BLOCKS  = 32;
  localparam int unsigned BCF_IDX_W      = 5;
  localparam int unsigned BCF_E_COUNT    = 1;
  localparam int unsigned BCF_CRC_W      = 12;
  localparam int unsigned BCF_FEC_W      = 26;
  localparam logic [4:0]  BCF_LAST_IDX   = 5'h1f;
  localparam logic [4:0]  BCF_FIRST_IDX  = 5'h00;
  localparam logic [11:0] BCF_CRC_TAPS   = 12'h30f;
  localparam logic [25:0] BCF_FEC_TAPS   = 26'h0220211;
  localparam logic [11:0] BCF_CRC_RESET  = 12'h000;
  localparam logic [25:0] BCF_FEC_RESET  = 26'h0000000;
  localparam int unsigned BCF_POS_EXT_MULTIBLOCK_END_BIT  = 22;
  localparam int unsigned BCF_POS_PILOT1 = 31;
  localparam logic [31:0] BCF_CRC_ONES   = 32'h80a88888;
  localparam logic [31:0] BCF_FEC_ONES   = 32'h80400000;
  localparam logic [31:0] BCF_PILOT      = 32'h80000000;
  localparam logic [31:0] BCF_ALL_ZERO   = 32'h00000000;
endpackage

/* File: bcf_rx_model.sv */
`timescale 1ns/10ps
module bcf_rx_model
  import bcf_pkg::*;
(
  input  wire logic                   clock_i,
  input  wire logic                   rst_n_i,
  input  wire logic [BCF_BLOCK_W-1:0] blk_i,
  input  wire logic                   vld_i,
  input  wire logic [BCF_IDX_W-1:0]   idx_i,
  output logic      [31:0]            word_o,
  output logic                        done_o,
  output logic                        bad_o
);
  logic [31:0] acc;
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
      bad_o <= 1'b0;
    end else begin
      done_o <= vld_i && idx_i == 5'h1f;
      if (vld_i) begin
        acc[idx_i] <= blk_i[1];
        bad_o <= bad_o | (blk_i[0] == blk_i[1]);
        if (idx_i == 5'h1f) word_o <= {blk_i[1], acc[30:0]};
      end
    end
  end
endmodule

/* File: testbench.sv */
`timescale 1ns/10ps
module testbench import bcf_pkg::*;;
  logic clock_i = 1'b0, rst_n_i = 1'b0, sysref_i = 1'b0, fec_mode_i = 1'b0;
  logic [63:0] block_data_i = '0;
  logic block_valid_i = 1'b0, block_valid_o, local_ext_multiblock_clock_o, rdone, rbad, pv;
  logic [65:0] block_o, pb;
  logic [4:0] block_index_o, idx, pi;
  logic [31:0] rword, mw, lastw;
  logic [25:0] crc, hc, fec, hf;
  int fail_count = 0, n_compared = 0;
  bcf_link_framer DUT (.clock_i, .rst_n_i, .sysref_i, .fec_mode_i, .block_data_i,
    .block_valid_i, .block_o, .block_valid_o, .block_index_o, .local_ext_multiblock_clock_o);
  bcf_rx_model u_rx (.clock_i, .rst_n_i, .blk_i(block_o), .vld_i(block_valid_o),
    .idx_i(block_index_o), .word_o(rword), .done_o(rdone), .bad_o(rbad));
  always #2.5 clock_i = ~clock_i;
  function automatic logic [25:0] lfsr(logic [25:0] s, logic [63:0] d, int w, logic [25:0] t);
    for (int p = 0; p < 64; p++)
      s = ((s << 1) ^ ((d[8*(p/8)+7-p%8] ^ s[w-1]) ? t : 26'h0)) & ((26'h1 << w) - 26'h1);
    return s;
  endfunction
  function automatic logic [31:0] sword(logic [11:0] c, logic [25:0] f, logic m);
    logic [31:0] w;
    w = m ? 32'h80400000 : 32'h80e88888;
    for (int i = 0; i < 26; i++) if (m) w[i < 22 ? i : i + 1] = f[25-i];
    for (int i = 0; i < 12; i++) if (!m) w[i + i/3] = c[11-i];
    return w;
  endfunction
  task automatic chk(input bit ok, input string m);
    n_compared++;
    if (!ok) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic results;
    if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input logic v, input logic [63:0] d);
    logic s;
    @(posedge clock_i);
    #1;
    if (rdone) chk(rword === lastw, "stream word");
    if (pv) begin
      chk(block_o === pb, "block");
      chk(block_index_o === pi, "index");
      if (pi == 5'h1f) lastw = mw;
    end
    chk(block_valid_o === pv && local_ext_multiblock_clock_o === (pv && pi == 5'h1f), "valid or tick");
    block_valid_i = v;
    block_data_i = d;
    pv = v;
    if (v) begin
      if (idx == 5'h00) {crc, fec, mw} = {52'h0, sword(hc[11:0], hf, fec_mode_i)};
      s = mw[idx];
      for (int p = 0; p < 64; p++) pb[p+2] = d[8*(p/8)+7-p%8];
      pb[1:0] = {s, ~s};
      crc = lfsr(crc, d, 12, 26'h30f);
      fec = lfsr(fec, d, 26, 26'h220211);
      pi = idx;
      if (idx == 5'h1f) {hc, hf} = {crc, fec};
      idx = idx + 5'h01;
    end
  endtask
  initial begin
    #20000;
    fail_count++;
    results;
  end
  initial begin
    void'($urandom(32'h8769));
    {pv, idx, hc, hf} = '0;
    repeat (8) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    for (int m = 0; m < 3; m++) begin
      sysref_i = 1'b1;
      repeat (2) cyc(1'b0, '0);
      sysref_i = 1'b0;
      repeat (6) cyc(1'b0, '0);
      idx = '0;
      fec_mode_i = m[0];
      for (int n = 0; n < 150; n++)
        cyc(n < 40 || $urandom % 4 != 0, n % 50 == 7 ? '1 : {$urandom, $urandom});
    end
    repeat (2) cyc(1'b0, '0);
    chk(rbad === 1'b0, "bad header seen");
    results;
  end
endmodule
